// File: tb/assa_engine_model.sv
// behavioural model of audio bus master engines 3, 4 and 5 seen from the aggregator
// assumes the bench pulses page_set and page_clr for one cycle, synchronous to clk
`default_nettype none

module assa_engine_model (
  input wire logic clk,
  input wire logic rst,
  input wire logic [2:0] en_req,
  input wire logic [2:0] page_set,
  input wire logic [2:0] page_clr,
  output logic [2:0] eng_enable,
  output logic [2:0] eng_end_of_page
);
  timeunit 1ns;
  timeprecision 1ps;

  // enable follows the engine's own control bit one cycle late
  always_ff @(posedge clk or posedge rst) begin
    if (rst) eng_enable <= 3'h0;
    else eng_enable <= en_req;
  end

  // page flag stays set until software clears it, so status cannot clear early
  always_ff @(posedge clk or posedge rst) begin
    if (rst) eng_end_of_page <= 3'h0;
    else eng_end_of_page <= (eng_end_of_page | page_set) & ~page_clr;
  end
endmodule

`default_nettype wire

// File: tb/test_audio_smi_status_aggregator.sv
// self-checking bench of the audio SMI status aggregator
// assumes assa_top and assa_engine_model; reads take one cycle
`default_nettype none
`include "assa_params.svh"

module test_audio_smi_status_aggregator;
  timeunit 1ns;
  timeprecision 1ps;
  logic clk = 1'b0;
  logic rst = 1'b1;
  logic [7:0] reg_addr = 8'h00;
  logic [15:0] reg_wdata = 16'h0000;
  logic reg_wr = 1'b0;
  logic reg_rd = 1'b0;
  logic [15:0] reg_rdata, rd_val;
  logic [2:0] en_req = 3'h0, page_set = 3'h0, page_clr = 3'h0;
  logic [2:0] eng_enable, eng_end_of_page;
  logic smi_request, irq;
  logic [2:0] exp_st = 3'h0, exp_en = 3'h0, exp_pg = 3'h0;
  logic [7:0] exp_mask = 8'hFF;
  int fail_count = 0, cmp_count = 0, cycles = 0;

  always #2 clk = ~clk;

  assa_top dut (.clk(clk), .rst(rst), .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr),
    .reg_rd(reg_rd), .reg_rdata(reg_rdata), .eng_enable(eng_enable),
    .eng_end_of_page(eng_end_of_page), .smi_request(smi_request), .irq(irq));

  assa_engine_model engines (.clk(clk), .rst(rst), .en_req(en_req), .page_set(page_set),
    .page_clr(page_clr), .eng_enable(eng_enable), .eng_end_of_page(eng_end_of_page));

  // status word layout: engine 3 at bit 5, engines 4 and 5 above it
  function automatic logic [15:0] st_word(input logic [2:0] s);
    return {8'h00, s, 5'h00};
  endfunction

  task automatic stop_test();
    $display("comparisons %0d mismatches %0d", cmp_count, fail_count);
    if (fail_count == 0 && cmp_count > 0) $display("TEST PASSED");
    else $display("TEST FAILED");
    $finish;
  endtask

  task automatic check(input string what, input logic [15:0] seen, input logic [15:0] exp);
    cmp_count++;
    if (seen !== exp) begin
      fail_count++;
      $display("CHECK FAILED %s expected %h seen %h", what, exp, seen);
    end
  endtask

  task automatic check_out();
    check("smi_request", {15'h0000, smi_request}, {15'h0000, |exp_st});
    check("irq", {15'h0000, irq}, {15'h0000, |(st_word(exp_st) & {8'h00, exp_mask})});
  endtask

  task automatic wr_reg(input logic [7:0] a, input logic [15:0] d);
    @(posedge clk);
    reg_addr <= a;
    reg_wdata <= d;
    reg_wr <= 1'b1;
    @(posedge clk);
    reg_wr <= 1'b0;
  endtask

  // read data stand only in the cycle after the strobe, so sample just past that edge
  task automatic rd_reg(input logic [7:0] a);
    @(posedge clk);
    reg_addr <= a;
    reg_rd <= 1'b1;
    @(posedge clk);
    reg_rd <= 1'b0;
    #1 rd_val = reg_rdata;
  endtask

  // engine levels change, then four edges let the flag and the status land
  task automatic engine(input logic [2:0] en, input logic [2:0] s, input logic [2:0] c);
    @(posedge clk);
    en_req <= en;
    page_set <= s;
    page_clr <= c;
    @(posedge clk);
    page_set <= 3'h0;
    page_clr <= 3'h0;
    repeat (3) @(posedge clk);
    exp_en = en;
    exp_pg = (exp_pg | s) & ~c;
    exp_st = exp_st | (exp_en & exp_pg);
  endtask

  // clearing read keeps bits whose flag is still set
  task automatic rd_status();
    rd_reg(`ASSA_OFF_STATUS);
    check("status", rd_val, st_word(exp_st));
    exp_st = (exp_st | exp_en) & exp_pg;
  endtask

  // a hang counts as a mismatch and ends the run
  always @(posedge clk) begin
    cycles <= cycles + 1;
    if (cycles == 4000) begin
      fail_count++;
      stop_test();
    end
  end

  initial begin
    void'($urandom(32'h7172));
    repeat (3) @(posedge clk);
    rst <= 1'b0;
    rd_status();
    check_out();
    rd_reg(`ASSA_OFF_MASK);
    check("mask", rd_val, 16'h00FF);
    rd_reg(8'h7E);
    check("unmapped", rd_val, 16'h0000);
    // flags raised with every engine disabled must not set status
    engine(3'h0, 3'h7, 3'h0);
    rd_reg(`ASSA_OFF_MIRROR);
    check("mirror", rd_val, 16'h0000);
    for (int i = 0; i < 3; i++) begin
      engine(3'h1 << i, 3'h0, 3'h0);
      rd_reg(`ASSA_OFF_MIRROR);
      check("mirror", rd_val, st_word(exp_st));
      check_out();
    end
    // repeated mirror reads and a status read with flags high leave every bit
    rd_reg(`ASSA_OFF_MIRROR);
    check("mirror", rd_val, 16'h00E0);
    rd_status();
    rd_reg(`ASSA_OFF_MIRROR);
    check("mirror", rd_val, 16'h00E0);
    wr_reg(`ASSA_OFF_STATUS, 16'h0000);
    wr_reg(`ASSA_OFF_MIRROR, 16'h0000);
    rd_reg(`ASSA_OFF_MIRROR);
    check("mirror", rd_val, 16'h00E0);
    engine(3'h0, 3'h0, 3'h7);
    rd_status();
    check_out();
    rd_status();
    // random engine traffic with mask changes and both kinds of read
    repeat (40) begin
      exp_mask = 8'($urandom);
      wr_reg(`ASSA_OFF_MASK, {8'($urandom), exp_mask});
      rd_reg(`ASSA_OFF_MASK);
      check("mask", rd_val, {8'h00, exp_mask});
      engine(3'($urandom), 3'($urandom), 3'($urandom));
      check_out();
      if ($urandom % 2) begin
        rd_status();
      end else begin
        rd_reg(`ASSA_OFF_MIRROR);
        check("mirror", rd_val, st_word(exp_st));
      end
      check_out();
    end
    stop_test();
  end
endmodule

`default_nettype wire

// File: verilog/assa_ctl_if.sv
// decoded register accesses passed from the port decoder to the core
// assumes one clock domain; signals are single-cycle strobes
`default_nettype none

interface assa_ctl_if;
  logic rd_status;
  logic rd_mirror;
  logic rd_mask;
  logic wr_mask;

  modport decoder (
    output rd_status,
    output rd_mirror,
    output rd_mask,
    output wr_mask
  );

  modport core (
    input rd_status,
    input rd_mirror,
    input rd_mask,
    input wr_mask
  );
endinterface

`default_nettype wire

// File: verilog/assa_params.svh
// offsets, bit positions, reset values and widths of the audio SMI status aggregator
// assumes inclusion by bare name from any file of the block
`ifndef ASSA_PARAMS_SVH
`define ASSA_PARAMS_SVH

// register offsets on the plain register port
`define ASSA_OFF_STATUS 8'h10
`define ASSA_OFF_MIRROR 8'h12
`define ASSA_OFF_MASK 8'h16

// address and data widths of the register port
`define ASSA_ADDR_W 8
`define ASSA_DATA_W 16

// status bit of engine 3; engines 4 and 5 sit in the two bits above
`define ASSA_ENG_BASE_BIT 5
`define ASSA_ENG_COUNT 3

// reset values
`define ASSA_STATUS_RST 16'h0000
`define ASSA_MASK_RST 8'hFF

`endif

// File: verilog/assa_pkg.sv
// types shared by the audio SMI status aggregator
// assumes assa_params.svh sits beside it
`default_nettype none
`include "assa_params.svh"

package assa_pkg;

  typedef logic [`ASSA_DATA_W-1:0] assa_word_type;
  typedef logic [`ASSA_ADDR_W-1:0] assa_addr_type;
  typedef logic [`ASSA_ENG_COUNT-1:0] assa_eng_type;

  // which register a port access hits
  typedef enum logic [1:0] {
    ASSA_ACC_NONE = 2'b00,
    ASSA_ACC_STATUS = 2'b01,
    ASSA_ACC_MIRROR = 2'b10,
    ASSA_ACC_MASK = 2'b11
  } assa_access_type;

endpackage

`default_nettype wire

// File: verilog/assa_reg_port.sv
// address decoder for the register port of the audio SMI status aggregator
// assumes strobes are one cycle long and never both high at once
`default_nettype none
`include "assa_params.svh"

module assa_reg_port (
  input wire logic [`ASSA_ADDR_W-1:0] addr,
  input wire logic wr,
  input wire logic rd,
  assa_ctl_if.decoder ctl
);

  // shared by the read and write paths
  function automatic assa_pkg::assa_access_type assa_decode(input logic [`ASSA_ADDR_W-1:0] a);
    case (a)
      `ASSA_OFF_STATUS: assa_decode = assa_pkg::ASSA_ACC_STATUS;
      `ASSA_OFF_MIRROR: assa_decode = assa_pkg::ASSA_ACC_MIRROR;
      `ASSA_OFF_MASK: assa_decode = assa_pkg::ASSA_ACC_MASK;
      default: assa_decode = assa_pkg::ASSA_ACC_NONE;
    endcase
  endfunction

  // writes to status and mirror are dropped: both are read-only to software
  assign ctl.rd_status = rd && (assa_decode(addr) == assa_pkg::ASSA_ACC_STATUS);
  assign ctl.rd_mirror = rd && (assa_decode(addr) == assa_pkg::ASSA_ACC_MIRROR);
  assign ctl.rd_mask = rd && (assa_decode(addr) == assa_pkg::ASSA_ACC_MASK);
  assign ctl.wr_mask = wr && (assa_decode(addr) == assa_pkg::ASSA_ACC_MASK);

endmodule

`default_nettype wire

// File: verilog/assa_status_bit.sv
// one sticky status bit for one audio bus master engine
// assumes enable and end_of_page are synchronous levels from the engine
`default_nettype none

module assa_status_bit (
  input wire logic clk,
  input wire logic rst,
  input wire logic enable,
  input wire logic end_of_page,
  input wire logic rd_clear,
  output logic status,
  output logic next_status
);

  logic set;

  // the engine only raises its bit while enabled and its page flag is set
  assign set = enable && end_of_page;

  // a read clears only once the page flag is gone; set always wins over clear
  assign next_status = set || (status && !(rd_clear && !end_of_page));

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      status <= 1'b0;
    end else begin
      status <= next_status;
    end
  end

endmodule

`default_nettype wire

// File: verilog/assa_top.sv
// second-level audio SMI status aggregator: status, mirror and mask registers
// assumes a plain register port with read data one cycle after the read strobe,
// and engine enable and end-of-page levels synchronous to clk
//
// What this block does
// - status bit 7 reads 1 when engine 5 caused the pending SMI
// - status bit 6 reads 1 when engine 4 caused the pending SMI
// - status bit 5 reads 1 when engine 3 caused the pending SMI
// - engine 5 raises its bit only while enabled, when its page flag sets
// - engine 4 raises its bit only while enabled, when its page flag sets
// - engine 3 raises its bit only while enabled, when its page flag sets
// - a read-only copy of the status stands at offset 12h
// - a status bit cannot clear while its engine's page flag is still set
// - reading the mirror copy leaves every status bit unchanged
//
// Register map, byte offsets on the register port:
//   10h  status; a read returns it and clears bits whose page flag is low
//   12h  mirror of the status; a read never clears anything
//   16h  mask; low byte read and write, upper byte of a write ignored
//   any other offset reads as zero and ignores writes
// Status and mask share one layout: bit 7 engine 5, bit 6 engine 4,
// bit 5 engine 3; the other status bits always read zero.
//
// Outputs:
//   reg_rdata    read answer, the cycle after the strobe only, zero otherwise
//   smi_request  high while any status bit is set; the mask does not apply
//   irq          high while a status bit is set and its mask bit was set a cycle earlier
//
// Timing: an enabled page flag sets its bit at the next edge, and smi_request
// rises at that same edge, as does irq when the engine's mask bit was set, so
// software never sees a request whose cause is not yet readable.
//
// Limitations: software cannot set or clear a bit by writing; the status
// and mirror offsets drop writes, and only a status read clears. A page flag
// that is still up keeps its bit, even across a clearing read in the same
// cycle, because a read clears only bits whose page flag is low.
//
// Hazards: the engine levels are taken as synchronous to clk; a source in
// another clock domain must be brought over by the engine before it lands
// here. The read strobe must never stand together with the write strobe.
//
// The register offsets and the address-and-strobe port were left to the implementer.
`default_nettype none
`include "assa_params.svh"

module assa_top #(
  parameter int ENG_COUNT = `ASSA_ENG_COUNT
) (
  input wire logic clk,
  input wire logic rst,
  input wire logic [`ASSA_ADDR_W-1:0] reg_addr,
  input wire logic [`ASSA_DATA_W-1:0] reg_wdata,
  input wire logic reg_wr,
  input wire logic reg_rd,
  output logic [`ASSA_DATA_W-1:0] reg_rdata,
  input wire logic [ENG_COUNT-1:0] eng_enable,
  input wire logic [ENG_COUNT-1:0] eng_end_of_page,
  output logic smi_request,
  output logic irq
);

  assa_ctl_if ctl ();

  // engine-indexed views of the status and mask; index 0 is engine 3
  logic [ENG_COUNT-1:0] status_bits;
  logic [ENG_COUNT-1:0] next_status_bits;
  logic [ENG_COUNT-1:0] mask_eng;
  logic [7:0] mask;
  assa_pkg::assa_word_type status_word;

  // address decode of the register port
  // writes to the status and mirror offsets never leave the decoder
  assa_reg_port u_port (
    .addr(reg_addr),
    .wr(reg_wr),
    .rd(reg_rd),
    .ctl(ctl)
  );

  // one sticky bit per engine; index 0 is engine 3, index 2 is engine 5
  // the clear strobe comes only from status reads, never from mirror reads
  generate
    for (genvar i = 0; i < ENG_COUNT; i++) begin : g_eng
      assa_status_bit u_bit (
        .clk(clk),
        .rst(rst),
        .enable(eng_enable[i]),
        .end_of_page(eng_end_of_page[i]),
        .rd_clear(ctl.rd_status),
        .status(status_bits[i]),
        .next_status(next_status_bits[i])
      );
    end
  endgenerate

  // place the engine bits; bits 15:8 and 4:0 read as zero
  // bits outside the engine span keep the reset value, so they can never leak
  always_comb begin
    status_word = `ASSA_STATUS_RST;
    for (int i = 0; i < ENG_COUNT; i++) begin
      status_word[`ASSA_ENG_BASE_BIT + i] = status_bits[i];
    end
  end

  // mask bits share the status layout, so engine bits line up
  // the mask keeps all eight bits so software reads back what it wrote
  always_comb begin
    for (int i = 0; i < ENG_COUNT; i++) begin
      mask_eng[i] = mask[`ASSA_ENG_BASE_BIT + i];
    end
  end

  // mask register; the upper byte of a write is ignored
  // a mask read right after a mask write already sees the new value
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      mask <= `ASSA_MASK_RST;
    end else if (ctl.wr_mask) begin
      mask <= reg_wdata[7:0];
    end
  end

  // read data stand for exactly the cycle after the strobe, zero otherwise
  // zero when idle, so a stale answer is never mistaken for a new one
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      reg_rdata <= `ASSA_STATUS_RST;
    end else if (ctl.rd_status || ctl.rd_mirror) begin
      reg_rdata <= status_word;
    end else if (ctl.rd_mask) begin
      reg_rdata <= {8'h00, mask};
    end else begin
      reg_rdata <= `ASSA_STATUS_RST;
    end
  end

  // built from next values so the outputs track the status bits with no lag
  // the request ignores the mask: the top-level logic decides what to do with it
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      smi_request <= 1'b0;
    end else begin
      smi_request <= |next_status_bits;
    end
  end

  // the masked interrupt; mask changes take effect one cycle after the write
  // irq uses the mask as it stood before the edge, hence that lag
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      irq <= 1'b0;
    end else begin
      irq <= |(next_status_bits & mask_eng);
    end
  end

  // checks of the behaviour above
  // all of them run on clk and are switched off while rst is high
  // rule checks come first, then the per-engine checks in a loop
  default clocking cb @(posedge clk);
  endclocking
  default disable iff (rst);

  // engine 5 bit rises only from its own enabled page flag
  a_eng5_cause: assert property ($rose(status_bits[2]) |-> $past(eng_enable[2] && eng_end_of_page[2]))
    else $error("engine 5 status set without its cause");

  // engine 4 bit rises only from its own enabled page flag
  a_eng4_cause: assert property ($rose(status_bits[1]) |-> $past(eng_enable[1] && eng_end_of_page[1]))
    else $error("engine 4 status set without its cause");

  // engine 3 bit rises only from its own enabled page flag
  a_eng3_cause: assert property ($rose(status_bits[0]) |-> $past(eng_enable[0] && eng_end_of_page[0]))
    else $error("engine 3 status set without its cause");

  // an enabled page flag sets the bit at the next edge
  a_eng_set: assert property ((eng_enable[2] && eng_end_of_page[2]) |=> status_bits[2])
    else $error("engine 5 event did not set its status bit");

  // a disabled engine with a clear bit stays clear
  a_eng_gate: assert property ((!eng_enable[1] && !status_bits[1]) |=> !status_bits[1])
    else $error("disabled engine 4 set its status bit");

  // two cycles of enabled page flag hold the bit high after each of them
  a_eng_hold: assert property ((eng_enable[0] && eng_end_of_page[0]) [*2] |-> status_bits[0] ##1 status_bits[0])
    else $error("engine 3 status dropped while its event held");

  // a mirror read answers with the status as it stood at the strobe
  a_mirror_data: assert property (ctl.rd_mirror |=> reg_rdata == $past(status_word))
    else $error("mirror read returned wrong data");

  // a set bit with its page flag still up survives any read
  a_flag_holds: assert property ((status_bits[2] && eng_end_of_page[2]) |=> status_bits[2])
    else $error("status cleared while page flag still set");

  // mirror reads never drop a bit
  a_mirror_keep: assert property (ctl.rd_mirror |=> (status_bits & $past(status_bits)) == $past(status_bits))
    else $error("mirror read cleared a status bit");

  // a status read clears every bit whose page flag was low
  a_read_clear: assert property (ctl.rd_status |=> (status_bits & ~$past(eng_end_of_page)) == '0)
    else $error("status read left a bit whose flag was clear");

  // the status read returns the bits as they stood before the clear
  a_read_data: assert property (ctl.rd_status |=> reg_rdata == $past(status_word))
    else $error("status read returned wrong data");

  // the SMI request follows the status bits exactly
  a_smi_level: assert property (smi_request == (|status_bits))
    else $error("smi request disagrees with status bits");

  // upper byte of a status or mirror read answer is zero
  a_upper_zero: assert property ((ctl.rd_status || ctl.rd_mirror) |=> reg_rdata[15:8] == 8'h00)
    else $error("reserved bits read nonzero");

  // zero also in the status bits below engine 3
  a_low_zero: assert property ((ctl.rd_status || ctl.rd_mirror) |=> reg_rdata[4:0] == 5'h00)
    else $error("status bits below engine 3 read nonzero");

  // a mask read answers with the low byte as it stood at the strobe
  a_mask_data: assert property (ctl.rd_mask |=> reg_rdata == {8'h00, $past(mask)})
    else $error("mask read returned wrong data");

  // a mask write lands at the next edge, upper byte dropped
  a_mask_write: assert property (ctl.wr_mask |=> mask == $past(reg_wdata[7:0]))
    else $error("mask write did not land");

  // with no read strobe the answer returns to zero
  a_rdata_idle: assert property (!(ctl.rd_status || ctl.rd_mirror || ctl.rd_mask) |=> reg_rdata == 16'h0000)
    else $error("read data stood without a read");

  // irq is the status seen through the mask held before the edge
  a_irq_level: assert property (irq == (|(status_bits & $past(mask_eng))))
    else $error("irq disagrees with masked status bits");

  // the masked interrupt never stands without the request
  a_irq_smi: assert property (irq |-> smi_request)
    else $error("irq high without smi request");

  // the SMI request rises only from an enabled page flag
  a_smi_rise: assert property ($rose(smi_request) |-> $past(|(eng_enable & eng_end_of_page)))
    else $error("smi request rose without a cause");

  // the SMI request falls only after a status read
  a_smi_fall: assert property ($fell(smi_request) |-> $past(ctl.rd_status))
    else $error("smi request fell without a status read");

  // a mirror read never removes a pending request
  a_mirror_quiet: assert property ((ctl.rd_mirror && smi_request) |=> smi_request)
    else $error("mirror read removed the smi request");

  // a write to any offset never clears a status bit
  a_write_keep: assert property (reg_wr |=> (status_bits & $past(status_bits)) == $past(status_bits))
    else $error("register write cleared a status bit");

  // a status read with every page flag low removes the request
  a_read_off: assert property ((ctl.rd_status && !(|eng_end_of_page)) |=> !smi_request)
    else $error("status read left the smi request up");

  // the same checks for every engine; index 0 is engine 3
  generate
    for (genvar k = 0; k < ENG_COUNT; k++) begin : g_chk
      // an enabled page flag sets the bit at the next edge
      a_set_each: assert property ((eng_enable[k] && eng_end_of_page[k]) |=>
        status_bits[k])
        else $error("enabled page flag did not set its status bit");

      // with the engine disabled and the bit clear, the bit stays clear
      a_gate_each: assert property ((!eng_enable[k] && !status_bits[k]) |=>
        !status_bits[k])
        else $error("disabled engine set its status bit");

      // a bit whose page flag is still up survives any read
      a_keep_each: assert property ((status_bits[k] && eng_end_of_page[k]) |=>
        status_bits[k])
        else $error("status bit cleared while its page flag was set");

      // a bit drops only at a status read that saw its page flag low
      a_drop_each: assert property ($fell(status_bits[k]) |->
        $past(ctl.rd_status && !eng_end_of_page[k]))
        else $error("status bit dropped without a clearing read");

      // both reads show the bit at its own place in the answer
      a_place_each: assert property ((ctl.rd_status || ctl.rd_mirror) |=>
        reg_rdata[`ASSA_ENG_BASE_BIT + k] == $past(status_bits[k]))
        else $error("engine status bit read at the wrong place");
    end
  endgenerate

  // main scenarios
  c_eng5_event: cover property ((eng_enable[2] && eng_end_of_page[2]) ##1 status_bits[2]);
  c_read_clears: cover property (status_bits[0] && !eng_end_of_page[0] && ctl.rd_status ##1 !status_bits[0]);
  c_mirror_set: cover property (status_bits[1] && ctl.rd_mirror ##1 status_bits[1]);
  c_masked_irq: cover property (smi_request && !irq);
  c_read_flag_up: cover property ((status_bits[2] && eng_end_of_page[2] && ctl.rd_status)
    ##1 status_bits[2]);

endmodule

`default_nettype wire
